// ---- interrupt_command_and_forcing_regs.sv ----
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
// Function
// - enable command ones set mask bits
// - disable command ones clear mask bits
// - clear command ones clear pending sources
// - set command ones make sources pending
// - any write to end-of-interrupt ends treatment
// - spurious address returned by normal vector read
// - spurious address returned by fast vector read
// - debug bit 0 enables protection mode
// - debug bit 1 holds both request lines inactive
// - fast-forcing enable ones set bits 1-31
// - fast-forcing disable ones clear forcing bits
// - fast-forcing status shows forcing per source
// - normal vector gives current vector or spurious
// - mask readout shows enabled sources
module interrupt_command_and_forcing_regs #(
  parameter logic [31:0] VECTOR_BASE = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Interrupt sources, on this clock, taken on rising edges
  input  wire logic [31:0] irq_sources,
  // Processor request lines, active low
  output logic             normal_request_line_n,
  output logic             fast_request_line_n,
  // Controller event interrupt
  output logic             event_irq
);

  if (VECTOR_BASE[1:0] != 2'h0) begin : g_check
    $error("VECTOR_BASE must be word aligned");
  end

  // Identifiers are five bits and each source owns one bit of the 32-bit data
  // word, so the source count cannot move away from the bus width.
  if (intc_pkg::NSRC != 32) begin : g_check_nsrc
    $error("NSRC must equal the data width of 32");
  end

  localparam int unsigned N = intc_pkg::NSRC;

  function automatic logic hit(input intc_pkg::bus_req_s r, input logic [intc_pkg::AW-1:0] off);
    hit = (r.addr == off);
  endfunction

  // Each source owns one word of the vector table above the base.
  function automatic logic [31:0] vector_of(input logic [4:0] id);
    vector_of = VECTOR_BASE | {25'h0, id, 2'h0};
  endfunction

  function automatic logic [4:0] lowest(input logic [N-1:0] v);
    logic [4:0] idx;
    idx = 5'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    lowest = idx;
  endfunction

  intc_pkg::bus_req_s req;
  logic               rd_fire;
  logic               wr_act;
  logic [N-1:0]       mask;
  logic [N-1:0]       pending;
  logic [N-1:0]       force_fast;
  logic [N-1:0]       src_q;
  logic [N-1:0]       spurious_vector;
  logic [1:0]         debug_control;
  logic               in_service;
  logic [4:0]         cur_id;
  logic [intc_pkg::NEV-1:0] ev_status;
  logic [intc_pkg::NEV-1:0] ev_enable;

  // Address phase capture; reads get one wait state so that a write
  // in the preceding data phase is already visible to them.
  logic accept;
  assign accept = hsel && hready && (htrans == intc_pkg::HTRANS_NONSEQ || htrans == intc_pkg::HTRANS_SEQ);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      req <= '0;
    end else if (accept) begin
      req.write <= hwrite;
      req.read  <= !hwrite;
      req.addr  <= haddr[intc_pkg::AW-1:0];
    end else if (hreadyout) begin
      req <= '0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(accept && !hwrite);
    end
  end

  // Every NONSEQ or SEQ transfer is served as a whole word whatever its size, so hsize is not decoded and
  // no transfer ever has cause for an error response.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign rd_fire = req.read && !hreadyout;
  assign wr_act  = req.write;

  logic wr_enable;
  logic wr_disable;
  logic wr_clear;
  logic wr_set;
  logic wr_eoi;
  logic wr_ffe;
  logic wr_ffd;
  assign wr_enable  = wr_act && hit(req, intc_pkg::OFF_ENABLE_CMD);
  assign wr_disable = wr_act && hit(req, intc_pkg::OFF_DISABLE_CMD);
  assign wr_clear   = wr_act && hit(req, intc_pkg::OFF_CLEAR_CMD);
  assign wr_set     = wr_act && hit(req, intc_pkg::OFF_SET_CMD);
  assign wr_eoi     = wr_act && hit(req, intc_pkg::OFF_EOI_CMD);
  assign wr_ffe     = wr_act && hit(req, intc_pkg::OFF_FF_ENABLE);
  assign wr_ffd     = wr_act && hit(req, intc_pkg::OFF_FF_DISABLE);

  // Forcing is meaningless for source 0, which is already the fast one.
  logic [N-1:0] ff_eff;
  logic [N-1:0] norm_cand;
  logic         norm_any;
  logic         fast_any;
  logic         fast_src0;
  assign ff_eff    = force_fast & intc_pkg::FF_VALID_BITS;
  assign norm_cand = pending & mask & ~ff_eff & intc_pkg::FF_VALID_BITS;
  assign norm_any  = |norm_cand;
  assign fast_src0 = pending[0] && mask[0];
  assign fast_any  = fast_src0 || (|(pending & mask & ff_eff));

  // In protection mode a read of the normal vector acknowledges nothing, though a spurious one still sets its event;
  // the debugger can look without acknowledging, and software then
  // acknowledges by writing the same location.
  logic protection_mode_enable;
  logic rd_normal;
  logic rd_fast;
  logic ack_normal;
  logic take_normal;
  logic take_fast;
  assign protection_mode_enable = debug_control[intc_pkg::DBG_PROTECTION_BIT];
  assign rd_normal   = rd_fire && hit(req, intc_pkg::OFF_NORMAL_VEC);
  assign rd_fast     = rd_fire && hit(req, intc_pkg::OFF_FAST_VEC);
  assign ack_normal  = protection_mode_enable ? (wr_act && hit(req, intc_pkg::OFF_NORMAL_VEC)) : rd_normal;
  assign take_normal = ack_normal && norm_any && !in_service;
  assign take_fast   = rd_fast && fast_src0;

  logic [N-1:0] edge_set;
  logic [N-1:0] ack_clear;
  logic [4:0]   pick;
  assign edge_set = irq_sources & ~src_q;
  assign pick     = lowest(norm_cand);

  always_comb begin
    ack_clear = '0;
    if (take_normal) begin
      ack_clear[pick] = 1'b1;
    end
    if (take_fast) begin
      ack_clear[0] = 1'b1;
    end
  end

  // Sources are taken on their rising edge; a source held high raises pending
  // once, and a clear then holds until the next edge.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      src_q <= '0;
    end else begin
      src_q <= irq_sources;
    end
  end

  // A new edge or set command wins over a clear in the same cycle.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~(wr_clear ? hwdata : intc_pkg::ZERO_WORD) & ~ack_clear)
                 | edge_set | (wr_set ? hwdata : intc_pkg::ZERO_WORD);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask <= '0;
    end else if (wr_enable) begin
      mask <= mask | hwdata;
    end else if (wr_disable) begin
      mask <= mask & ~hwdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      force_fast <= '0;
    end else if (wr_ffe) begin
      force_fast <= force_fast | (hwdata & intc_pkg::FF_VALID_BITS);
    end else if (wr_ffd) begin
      force_fast <= force_fast & ~(hwdata & intc_pkg::FF_VALID_BITS);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      spurious_vector <= intc_pkg::SPURIOUS_RESET;
    end else if (wr_act && hit(req, intc_pkg::OFF_SPURIOUS)) begin
      spurious_vector <= hwdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      debug_control <= intc_pkg::DBG_RESET;
    end else if (wr_act && hit(req, intc_pkg::OFF_DEBUG_CTRL)) begin
      debug_control <= hwdata[1:0];
    end
  end

  // One interrupt in service at a time; the normal line stays quiet
  // until end of interrupt is written.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      in_service <= 1'b0;
      cur_id     <= 5'h0;
    end else if (take_normal) begin
      in_service <= 1'b1;
      cur_id     <= pick;
    end else if (wr_eoi) begin
      in_service <= 1'b0;
    end
  end

  // Read data, registered at the end of the wait state.
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    case (req.addr)
      intc_pkg::OFF_NORMAL_VEC: begin
        if (in_service && !take_normal) begin
          next_rdata = vector_of(cur_id);
        end else if (norm_any && (!in_service || protection_mode_enable)) begin
          next_rdata = vector_of(pick);
        end else begin
          next_rdata = spurious_vector;
        end
      end
      intc_pkg::OFF_FAST_VEC:   next_rdata = fast_src0 ? VECTOR_BASE : spurious_vector;
      intc_pkg::OFF_MASK_RD:    next_rdata = mask;
      intc_pkg::OFF_SPURIOUS:   next_rdata = spurious_vector;
      intc_pkg::OFF_DEBUG_CTRL: next_rdata = {30'h0, debug_control};
      intc_pkg::OFF_FF_STATUS:  next_rdata = ff_eff;
      intc_pkg::OFF_PENDING_RD: next_rdata = pending;
      intc_pkg::OFF_EV_STATUS:  next_rdata = {29'h0, ev_status};
      intc_pkg::OFF_EV_ENABLE:  next_rdata = {29'h0, ev_enable};
      default:                  next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hrdata <= '0;
    end else if (rd_fire) begin
      hrdata <= next_rdata;
    end
  end

  // Request lines, registered; the general mask forces them inactive.
  // Registering costs a cycle of latency but keeps glitches of the candidate
  // logic away from the processor's inputs.
  logic global_line_mask;
  assign global_line_mask = debug_control[intc_pkg::DBG_LINE_MASK_BIT];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      normal_request_line_n <= 1'b1;
      fast_request_line_n   <= 1'b1;
    end else begin
      normal_request_line_n <= !(norm_any && !in_service && !global_line_mask);
      fast_request_line_n   <= !(fast_any && !global_line_mask);
    end
  end

  // Controller events: sticky, set wins over a clear in the same cycle.
  logic [intc_pkg::NEV-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[intc_pkg::EV_SPUR_NORMAL] = rd_normal && !norm_any && !in_service;
    ev_set[intc_pkg::EV_SPUR_FAST]   = rd_fast && !fast_src0;
    ev_set[intc_pkg::EV_EOI]         = wr_eoi;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ev_status <= '0;
    end else if (wr_act && hit(req, intc_pkg::OFF_EV_CLEAR)) begin
      ev_status <= (ev_status & ~hwdata[intc_pkg::NEV-1:0]) | ev_set;
    end else begin
      ev_status <= ev_status | ev_set;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ev_enable <= '0;
    end else if (wr_act && hit(req, intc_pkg::OFF_EV_ENABLE)) begin
      ev_enable <= hwdata[intc_pkg::NEV-1:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(ev_status & ev_enable);
    end
  end

endmodule

// ---- intc_pkg.sv ----
package intc_pkg;

  localparam int unsigned NSRC = 32;
  localparam int unsigned AW   = 8;
  localparam int unsigned NEV  = 3;

  // Word offsets of the register map, as byte addresses.
  localparam logic [AW-1:0] OFF_NORMAL_VEC   = 8'h00;
  localparam logic [AW-1:0] OFF_FAST_VEC     = 8'h04;
  localparam logic [AW-1:0] OFF_MASK_RD      = 8'h08;
  localparam logic [AW-1:0] OFF_ENABLE_CMD   = 8'h0c;
  localparam logic [AW-1:0] OFF_DISABLE_CMD  = 8'h10;
  localparam logic [AW-1:0] OFF_CLEAR_CMD    = 8'h14;
  localparam logic [AW-1:0] OFF_SET_CMD      = 8'h18;
  localparam logic [AW-1:0] OFF_EOI_CMD      = 8'h1c;
  localparam logic [AW-1:0] OFF_SPURIOUS     = 8'h20;
  localparam logic [AW-1:0] OFF_DEBUG_CTRL   = 8'h24;
  localparam logic [AW-1:0] OFF_FF_ENABLE    = 8'h28;
  localparam logic [AW-1:0] OFF_FF_DISABLE   = 8'h2c;
  localparam logic [AW-1:0] OFF_FF_STATUS    = 8'h30;
  localparam logic [AW-1:0] OFF_PENDING_RD   = 8'h34;
  localparam logic [AW-1:0] OFF_EV_STATUS    = 8'h38;
  localparam logic [AW-1:0] OFF_EV_CLEAR     = 8'h3c;
  localparam logic [AW-1:0] OFF_EV_ENABLE    = 8'h40;

  // Debug control fields.
  localparam int unsigned DBG_PROTECTION_BIT = 0;
  localparam int unsigned DBG_LINE_MASK_BIT  = 1;
  localparam logic [1:0]  DBG_RESET          = 2'h0;

  // Event status bits.
  localparam int unsigned EV_SPUR_NORMAL = 0;
  localparam int unsigned EV_SPUR_FAST   = 1;
  localparam int unsigned EV_EOI         = 2;

  // Source 0 cannot be fast forced; its bit is reserved there.
  localparam logic [NSRC-1:0] FF_VALID_BITS = 32'hffff_fffe;
  localparam logic [NSRC-1:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [NSRC-1:0] SPURIOUS_RESET = 32'h0000_0000;
  localparam logic [1:0]      HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]      HTRANS_SEQ    = 2'h3;

  // Address phase held over into the data phase.
  typedef struct packed {
    logic          write;
    logic          read;
    logic [AW-1:0] addr;
  } bus_req_s;

endpackage

// ---- intc_regs_monitor.sv ----
`timescale 1ns/100ps
module intc_regs_monitor (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        normal_request_line_n,
  input wire logic        fast_request_line_n
);
  logic       a_wr, a_rd, take, wd, rd;
  logic [7:0] a;
  logic [31:0] msk, ffs, spur;
  logic [1:0]  dbg;
  assign take = hsel && hready && htrans[1];
  assign wd   = a_wr && hready;
  assign rd   = a_rd && hready;
  // Shadow state is rebuilt from bus traffic alone, so checks stay independent of the design body.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {a_wr, a_rd, a, msk, ffs, spur, dbg} <= '0;
    end else begin
      if (hready) begin
        a_wr <= take && hwrite;
        a_rd <= take && !hwrite;
        a    <= haddr[7:0];
      end
      if (wd && a == intc_pkg::OFF_ENABLE_CMD) msk <= msk | hwdata;
      if (wd && a == intc_pkg::OFF_DISABLE_CMD) msk <= msk & ~hwdata;
      if (wd && a == intc_pkg::OFF_FF_ENABLE) ffs <= ffs | (hwdata & intc_pkg::FF_VALID_BITS);
      if (wd && a == intc_pkg::OFF_FF_DISABLE) ffs <= ffs & ~hwdata;
      if (wd && a == intc_pkg::OFF_SPURIOUS) spur <= hwdata;
      if (wd && a == intc_pkg::OFF_DEBUG_CTRL) dbg <= hwdata[1:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  mask_readback_a: assert property (rd && a == intc_pkg::OFF_MASK_RD |-> hrdata == msk)
    else $error("mask readout differs from commanded mask");
  ff_status_a: assert property (rd && a == intc_pkg::OFF_FF_STATUS |-> hrdata == ffs)
    else $error("fast forcing status differs from commands");
  ff_reserved_a: assert property (rd && a == intc_pkg::OFF_FF_STATUS |-> !hrdata[0])
    else $error("fast forcing bit 0 is set");
  spur_readback_a: assert property (rd && a == intc_pkg::OFF_SPURIOUS |-> hrdata == spur)
    else $error("spurious vector readback wrong");
  debug_readback_a: assert property (rd && a == intc_pkg::OFF_DEBUG_CTRL |-> hrdata == {30'h0, dbg})
    else $error("debug control readback wrong");
  wo_read_zero_a: assert property (rd && a >= intc_pkg::OFF_ENABLE_CMD && a <= intc_pkg::OFF_EOI_CMD
    |-> hrdata == 32'h0)
    else $error("write-only register read nonzero");
  line_mask_a: assert property (dbg[1] && $past(dbg[1]) |-> normal_request_line_n && fast_request_line_n)
    else $error("request line active under global mask");
  no_mask_idle_a: assert property (msk == 32'h0 && $past(msk) == 32'h0
    |-> normal_request_line_n && fast_request_line_n)
    else $error("request line active with all sources disabled");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  mask_rd_c: cover property (rd && a == intc_pkg::OFF_MASK_RD && hrdata != 32'h0);
  line_mask_c: cover property (dbg[1] && $past(dbg[1]));
  fast_c: cover property (!fast_request_line_n);
endmodule
bind interrupt_command_and_forcing_regs intc_regs_monitor i_intc_regs_monitor (
  .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));

// ---- core_model.sv ----
`timescale 1ns/100ps
module core_model (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic normal_request_line_n,
  input  wire logic fast_request_line_n,
  output logic      normal_seen,
  output logic      fast_seen
);
  // The core only samples the active-low lines on its clock; it never drives the controller.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      normal_seen <= 1'b0;
      fast_seen   <= 1'b0;
    end else begin
      normal_seen <= !normal_request_line_n;
      fast_seen   <= !fast_request_line_n;
    end
  end
endmodule

// ---- interrupt_command_and_forcing_regs_tb_top.sv ----
`timescale 1ns/100ps
module interrupt_command_and_forcing_regs_tb_top;
  logic        mclk = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, irq_sources = '0, hrdata, rv;
  logic [1:0]  htrans = '0;
  logic        hreadyout, hresp, normal_request_line_n, fast_request_line_n, event_irq, normal_seen, fast_seen;
  int          fail_count = 0, check_count = 0;
  always #10 mclk = ~mclk;
  interrupt_command_and_forcing_regs i_interrupt_command_and_forcing_regs (.mclk(mclk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_sources(irq_sources),
    .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n),
    .event_irq(event_irq));
  core_model i_core_model (.mclk(mclk), .reset(reset), .normal_request_line_n(normal_request_line_n),
    .fast_request_line_n(fast_request_line_n), .normal_seen(normal_seen), .fast_seen(fast_seen));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= intc_pkg::HTRANS_NONSEQ; hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(a, 0, 32'h0);
    chk(n, e, rv);
  endtask
  task automatic t_reset_vals;
    rdc("spurious", intc_pkg::OFF_SPURIOUS, intc_pkg::SPURIOUS_RESET);
    rdc("debug", intc_pkg::OFF_DEBUG_CTRL, 32'h0);
    rdc("mask", intc_pkg::OFF_MASK_RD, 32'h0);
    rdc("ff status", intc_pkg::OFF_FF_STATUS, 32'h0);
    chk("hresp", 0, hresp);
    $display("reset values done");
  endtask
  task automatic t_mask;
    xfer(intc_pkg::OFF_ENABLE_CMD, 1, 32'h8000_0006);
    xfer(intc_pkg::OFF_ENABLE_CMD, 1, 32'h0);
    rdc("mask", intc_pkg::OFF_MASK_RD, 32'h8000_0006);
    xfer(intc_pkg::OFF_DISABLE_CMD, 1, 32'h0000_0004);
    rdc("mask", intc_pkg::OFF_MASK_RD, 32'h8000_0002);
    xfer(intc_pkg::OFF_FF_ENABLE, 1, 32'hffff_ffff);
    xfer(intc_pkg::OFF_FF_DISABLE, 1, 32'h0000_ff00);
    rdc("ff status", intc_pkg::OFF_FF_STATUS, 32'hffff_00fe);
    $display("mask and forcing done");
  endtask
  task automatic t_spurious;
    xfer(intc_pkg::OFF_SPURIOUS, 1, 32'ha5a5_5a5c);
    xfer(intc_pkg::OFF_EV_ENABLE, 1, 32'h7);
    rdc("normal vector", intc_pkg::OFF_NORMAL_VEC, 32'ha5a5_5a5c);
    rdc("fast vector", intc_pkg::OFF_FAST_VEC, 32'ha5a5_5a5c);
    rdc("events", intc_pkg::OFF_EV_STATUS, 32'h3);
    chk("event irq", 1, event_irq);
    xfer(intc_pkg::OFF_EV_ENABLE, 1, 32'h4);
    repeat (2) @(posedge mclk);
    chk("event irq masked", 0, event_irq);
    xfer(intc_pkg::OFF_EV_CLEAR, 1, 32'h3);
    $display("spurious done");
  endtask
  task automatic t_pending;
    // Source 1 is still fast forced from the mask test; route it back to the normal line.
    xfer(intc_pkg::OFF_FF_DISABLE, 1, 32'h0000_0002);
    xfer(intc_pkg::OFF_SET_CMD, 1, 32'h0000_0002);
    irq_sources <= 32'h20;
    rdc("pending", intc_pkg::OFF_PENDING_RD, 32'h22);
    chk("core normal", 1, normal_seen);
    rdc("normal vector", intc_pkg::OFF_NORMAL_VEC, 32'h4);
    repeat (3) @(posedge mclk);
    chk("core normal served", 0, normal_seen);
    xfer(intc_pkg::OFF_EOI_CMD, 1, 32'h5a5a_0000);
    rdc("events", intc_pkg::OFF_EV_STATUS, 32'h4);
    chk("eoi irq", 1, event_irq);
    xfer(intc_pkg::OFF_SET_CMD, 1, 32'h8000_0000);
    repeat (3) @(posedge mclk);
    chk("core fast", 1, fast_seen);
    xfer(intc_pkg::OFF_DEBUG_CTRL, 1, 32'h3);
    repeat (3) @(posedge mclk);
    chk("core fast masked", 0, fast_seen);
    rdc("debug", intc_pkg::OFF_DEBUG_CTRL, 32'h3);
    xfer(intc_pkg::OFF_CLEAR_CMD, 1, 32'h8000_0020);
    rdc("pending", intc_pkg::OFF_PENDING_RD, 32'h0);
    // Protection mode is on: a vector read must not acknowledge, a write to it must.
    xfer(intc_pkg::OFF_SET_CMD, 1, 32'h0000_0002);
    rdc("protection_mode_enable vector", intc_pkg::OFF_NORMAL_VEC, 32'h4);
    rdc("protection_mode_enable pending kept", intc_pkg::OFF_PENDING_RD, 32'h2);
    xfer(intc_pkg::OFF_NORMAL_VEC, 1, 32'h0);
    rdc("protection_mode_enable pending acked", intc_pkg::OFF_PENDING_RD, 32'h0);
    rdc("protection_mode_enable in service", intc_pkg::OFF_NORMAL_VEC, 32'h4);
    xfer(intc_pkg::OFF_EOI_CMD, 1, 32'h0);
    $display("pending done");
  endtask
  task automatic t_wo_reads;
    logic [7:0] wo [8] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h28, 8'h2c, 8'h80};
    foreach (wo[i]) rdc("write-only", wo[i], 32'h0);
    rdc("mask kept", intc_pkg::OFF_MASK_RD, 32'h8000_0002);
    $display("write-only reads done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    t_reset_vals();
    t_mask();
    t_spurious();
    t_pending();
    t_wo_reads();
    end_of_test();
  end
endmodule
